// File: design/fnm_regs.svh
// Register offsets, field positions, reset values and opcodes
`ifndef FNM_REGS_SVH
`define FNM_REGS_SVH
`define FNM_CTRL_OFS   12'h000
`define FNM_STAT_OFS   12'h004
`define FNM_COND_OFS   12'h008
`define FNM_CTRL_RST   32'h0000_0000
`define FNM_STAT_RST   32'h0000_0000
`define FNM_COND_RST   4'h0
`define FNM_PSE_BIT    0
`define FNM_FX_BIT     31
`define FNM_FEX_BIT    30
`define FNM_VX_BIT     29
`define FNM_OX_BIT     28
`define FNM_UX_BIT     27
`define FNM_ZX_BIT     26
`define FNM_XX_BIT     25
`define FNM_VXSN_BIT   24
`define FNM_VXII_BIT   23
`define FNM_VXIZ_BIT   20
`define FNM_FR_BIT     18
`define FNM_FI_BIT     17
`define FNM_CLS_LSB    12
`define FNM_VE_BIT     7
`define FNM_OE_BIT     6
`define FNM_UE_BIT     5
`define FNM_ZE_BIT     4
`define FNM_XE_BIT     3
`define FNM_RND_LSB    0
`define FNM_VXANY_MSK  32'h01F8_0700
`define FNM_PRIM_DBL   6'h3F
`define FNM_PRIM_SGL   6'h3B
`define FNM_XO_NABS    10'h088
`define FNM_XO_NEG     10'h028
`define FNM_XO_NMADD   5'h1F
`define FNM_XO_NMSUB   5'h1E
`define FNM_DFLT_QNAN  64'h7FF8_0000_0000_0000
`define FNM_QUIET_MSK  64'h0008_0000_0000_0000
`define FNM_SGL_REBIAS 11'h380
`endif

// File: design/fnm_pkg.sv
// Types shared by the negate and negative multiply-add unit
package fnm_pkg;
  typedef enum logic [2:0] {
    FNM_OP_NONE, FNM_OP_NABS, FNM_OP_NEG,
    FNM_OP_NMADD, FNM_OP_NMSUB, FNM_OP_NMADDS
  } fnm_op_e;
  typedef logic [4:0] fnm_class_t;
endpackage

// File: design/fnm_unit.sv
// Negate, force-negative and negative multiply-add execution slice
// Operation
// - force-negative sets operand sign bit
// - sign-invert complements operand sign bit only
// - sign ops alter NaNs, leave status alone
// - record bit copies summaries to condition field
// - plain and dotted forms share operand fields
// - double neg multiply-add: product plus addend, negated
// - normalize sum before rounding
// - round double under rounding_select, then negate
// - single neg multiply-add rounds single, then negates
// - paired mode: low slots in, both slots out
// - quiet NaN operand keeps its sign
// - default quiet NaN from invalid is positive
// - quieted signaling NaN keeps its sign
// - class field skipped on trapped invalid
// - arithmetic ops update listed status bits
// - double neg multiply-subtract, round, negate
`timescale 1ns/1ps
`include "fnm_regs.svh"
module fnm_unit
  import fnm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        inst_valid,
  input  wire logic [31:0] inst_word,
  input  wire logic [63:0] opnd_a,
  input  wire logic [63:0] opnd_b,
  input  wire logic [63:0] opnd_c,
  output logic             res_valid,
  output logic             res_we,
  output logic      [4:0]  res_target,
  output logic      [63:0] res_data,
  output logic             cond_we,
  output logic      [3:0]  cond_data
);
  // ==========================================================
  // Helper functions
  // Merge write data under byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] o,
    input logic [31:0] w, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (s[i]) o[8*i +: 8] = w[8*i +: 8];
    return o;
  endfunction
  // Widen a single-format value to double format
  function automatic logic [63:0] sgl_to_dbl(input logic [31:0] s);
    logic [10:0] e;
    logic [22:0] f;
    e = 11'(s[30:23]) + `FNM_SGL_REBIAS;
    f = s[22:0];
    if (s[30:23] == 8'hFF) e = 11'h7FF;
    else if (s[30:23] == 8'h00) begin
      if (f == 23'h0) e = 11'h000;
      else begin
        e = `FNM_SGL_REBIAS;
        for (int k = 0; k < 23; k++) if (!f[22]) begin
          f = f << 1;
          e = e - 11'd1;
        end
        f = f << 1;
      end
    end
    return {s[31], e, f, 29'h0};
  endfunction
  // Result class and sign code
  function automatic fnm_class_t class_of(input logic s, input logic eo,
    input logic ez, input logic fz);
    if (eo) return fz ? (s ? 5'h09 : 5'h05) : 5'h11;
    if (ez) return fz ? (s ? 5'h12 : 5'h02) : (s ? 5'h18 : 5'h14);
    return s ? 5'h08 : 5'h04;
  endfunction
  // Right shift keeping lost bits as a sticky lsb
  function automatic logic [169:0] shr_st(input logic [169:0] x,
    input int n);
    logic [169:0] y;
    int m;
    m = (n > 169) ? 170 : n;
    y = x >> m;
    y[0] = y[0] | (|(x & ~({170{1'b1}} << m)));
    return y;
  endfunction
  // ==========================================================
  // Registers and working signals
  logic [31:0]  ctrl;          // Paired-single enable
  logic [31:0]  stat;          // Float status and control
  logic [31:0]  next_stat;     // Status after this cycle
  fnm_op_e      op;            // Decoded operation
  logic         paired_single_enable;           // paired_single_enable
  logic [1:0]   rnd;           // rounding_select
  logic         sgl, ps_in;    // Single result, paired operands
  logic [63:0]  a_d, b_d, c_d; // Operands in double format
  logic         na, nb, nc, sna, snb, snc, ia, ib, ic, za, zc;
  logic         sp, sbe, imz, isi, snan, inv, nan_in, p_inf;
  int           ea, eb, ec, ep, ex, lz, ee, emin, emax, pw;
  logic [169:0] fx, fy, fr, jst;
  logic [53:0]  kept;
  logic         rs, gd, st, inc, tiny, ovf, xr, zr;
  logic [63:0]  dres;          // Unnegated double result
  logic [31:0]  sres;          // Unnegated single result
  logic [31:0]  pres;          // Paired slot result image
  logic [63:0]  fin;           // Final register image
  fnm_class_t   cls;           // Final result class
  logic         arith;         // Multiply-add family
  logic         wr_ok;         // Target may be written
  logic         apb_wr;        // Write taken this edge
  // ==========================================================
  // Decode, same operand fields for both record forms
  always_comb begin
    op = FNM_OP_NONE;
    if (inst_word[31:26] == `FNM_PRIM_DBL) begin
      if (inst_word[10:1] == `FNM_XO_NABS) op = FNM_OP_NABS;
      else if (inst_word[10:1] == `FNM_XO_NEG) op = FNM_OP_NEG;
      else if (inst_word[5:1] == `FNM_XO_NMADD) op = FNM_OP_NMADD;
      else if (inst_word[5:1] == `FNM_XO_NMSUB) op = FNM_OP_NMSUB;
    end else if (inst_word[31:26] == `FNM_PRIM_SGL &&
                 inst_word[5:1] == `FNM_XO_NMADD) begin
      op = FNM_OP_NMADDS;
    end
  end
  assign paired_single_enable   = ctrl[`FNM_PSE_BIT];
  assign rnd   = stat[`FNM_RND_LSB +: 2];
  assign sgl   = (op == FNM_OP_NMADDS);
  assign ps_in = sgl & paired_single_enable;
  assign arith = inst_valid & (op inside {FNM_OP_NMADD, FNM_OP_NMSUB,
                                          FNM_OP_NMADDS});
  // ==========================================================
  // Operand unpacking and special cases
  always_comb begin
    a_d = ps_in ? sgl_to_dbl(opnd_a[31:0]) : opnd_a;
    b_d = ps_in ? sgl_to_dbl(opnd_b[31:0]) : opnd_b;
    c_d = ps_in ? sgl_to_dbl(opnd_c[31:0]) : opnd_c;
    na  = (&a_d[62:52]) & (|a_d[51:0]);
    nb  = (&b_d[62:52]) & (|b_d[51:0]);
    nc  = (&c_d[62:52]) & (|c_d[51:0]);
    sna = na & ~a_d[51];
    snb = nb & ~b_d[51];
    snc = nc & ~c_d[51];
    ia  = (&a_d[62:52]) & ~(|a_d[51:0]);
    ib  = (&b_d[62:52]) & ~(|b_d[51:0]);
    ic  = (&c_d[62:52]) & ~(|c_d[51:0]);
    za  = ~(|a_d[62:0]);
    zc  = ~(|c_d[62:0]);
    sp  = a_d[63] ^ c_d[63];
    sbe = b_d[63] ^ (op == FNM_OP_NMSUB);
    nan_in = na | nb | nc;
    snan   = sna | snb | snc;
    imz    = ~na & ~nc & ((ia & zc) | (za & ic));
    p_inf  = (ia | ic) & ~imz;
    isi    = ~nan_in & p_inf & ib & (sp != sbe);
    inv    = snan | imz | isi;
  end
  // ==========================================================
  // Aligned add, normalize, round
  always_comb begin
    ea = (a_d[62:52] == 11'h0) ? 1 : int'(a_d[62:52]);
    ec = (c_d[62:52] == 11'h0) ? 1 : int'(c_d[62:52]);
    eb = (b_d[62:52] == 11'h0) ? 1 : int'(b_d[62:52]);
    ep = ea + ec - 1075;
    ex = (ep > eb) ? ep : eb;
    fx = {2'b0, 55'h0, |a_d[62:52], a_d[51:0], 60'h0}
         * {|c_d[62:52], c_d[51:0]};
    fx = shr_st(fx, ex - ep);
    fy = shr_st({57'h0, |b_d[62:52], b_d[51:0], 60'h0}, ex - eb);
    rs = sp;
    if (sp == sbe) fr = fx + fy;
    else if (fx >= fy) fr = fx - fy;
    else begin
      fr = fy - fx;
      rs = sbe;
    end
    zr = (fr == 170'h0);
    if (zr) rs = (sp == sbe) ? sp : (rnd == 2'd3);
    lz = 0;
    for (int i = 0; i < 170; i++) if (fr[i]) lz = 169 - i;
    jst  = fr << lz;
    ee   = ex + 57 - lz;
    pw   = sgl ? 24 : 53;
    emin = sgl ? 897 : 1;
    emax = sgl ? 1150 : 2046;
    tiny = ~zr & (ee < emin);
    if (tiny) begin
      jst = shr_st(jst, emin - ee);
      ee  = emin;
    end
    kept = 54'(jst >> (170 - pw));
    gd   = jst[169 - pw];
    st   = |(jst << (pw + 1));
    xr   = gd | st;
    case (rnd)
      2'd0:    inc = gd & (st | kept[0]);
      2'd1:    inc = 1'b0;
      2'd2:    inc = xr & ~rs;
      2'd3:    inc = xr & rs;
      default: inc = 1'b0;
    endcase
    kept = kept + 54'(inc);
    if (kept[pw]) begin
      kept = kept >> 1;
      ee   = ee + 1;
    end
    if (~kept[pw - 1]) ee = 0;
    ovf = ~zr & (ee > emax);
    if (ovf) xr = 1'b1;
    dres = {rs, 11'(ee), kept[51:0]};
    sres = {rs, 8'(ee - 896), kept[22:0]};
    if (zr) begin
      dres = {rs, 63'h0};
      sres = {rs, 31'h0};
    end else if (ovf) begin
      if (rnd == 2'd1 || (rnd == 2'd2 && rs) || (rnd == 2'd3 && !rs)) begin
        dres = {rs, 11'h7FE, {52{1'b1}}};
        sres = {rs, 8'hFE, {23{1'b1}}};
      end else begin
        dres = {rs, 11'h7FF, 52'h0};
        sres = {rs, 8'hFF, 23'h0};
      end
    end
  end
  // ==========================================================
  // Result selection, negation, class
  always_comb begin
    fin  = '0;
    cls  = 5'h0;
    pres = 32'h0000_0000;
    if (op == FNM_OP_NABS) fin = opnd_b | {1'b1, 63'h0};
    else if (op == FNM_OP_NEG) begin
      fin = {~opnd_b[63], opnd_b[62:0]};
    end else if (nan_in) begin
      // Quiet NaN passes unnegated, signaling NaN is quieted
      if (na) fin = a_d | `FNM_QUIET_MSK;
      else if (nb) fin = b_d | `FNM_QUIET_MSK;
      else fin = c_d | `FNM_QUIET_MSK;
    end else if (inv) fin = `FNM_DFLT_QNAN;
    else if (p_inf) fin = {~sp, 11'h7FF, 52'h0};
    else if (ib) fin = {~sbe, 11'h7FF, 52'h0};
    else if (sgl) fin = sgl_to_dbl({~sres[31], sres[30:0]});
    else fin = {~dres[63], dres[62:0]};
    if (sgl && fin[62:52] == 11'h7FF) fin[28:0] = 29'h0;
    if (ps_in) begin
      pres = (fin[62:52] == 11'h7FF) ? {fin[63], 8'hFF, fin[51:29]}
           : (nan_in | inv | p_inf | ib) ? 32'h0
           : {~sres[31], sres[30:0]};
      if (p_inf | ib) pres = {fin[63], 8'hFF, 23'h0};
      fin = {pres, pres};
    end
    // Class of what lands in the target
    if (sgl && !(fin[62:52] == 11'h7FF) && !ps_in && !zr)
      cls = class_of(~sres[31], 1'b0, ~(|sres[30:23]), 1'b0);
    else if (ps_in)
      cls = class_of(fin[31], &fin[30:23], ~(|fin[30:23]),
                     ~(|fin[22:0]));
    else
      cls = class_of(fin[63], &fin[62:52], ~(|fin[62:52]),
                     ~(|fin[51:0]));
  end
  assign wr_ok = ~(arith & inv & stat[`FNM_VE_BIT]);
  assign apb_wr = psel & penable & pready & pwrite;
  // ==========================================================
  // Status next value, hardware sets win over a software write
  always_comb begin
    next_stat = stat;
    if (apb_wr && paddr == `FNM_STAT_OFS)
      next_stat = strb_merge(stat, pwdata, pstrb);
    if (arith) begin
      next_stat[`FNM_VXSN_BIT] = next_stat[`FNM_VXSN_BIT] | snan;
      next_stat[`FNM_VXIZ_BIT] = next_stat[`FNM_VXIZ_BIT] | imz;
      next_stat[`FNM_VXII_BIT] = next_stat[`FNM_VXII_BIT] | isi;
      if (!inv && !nan_in && !p_inf && !ib) begin
        next_stat[`FNM_OX_BIT] = next_stat[`FNM_OX_BIT] | ovf;
        next_stat[`FNM_UX_BIT] = next_stat[`FNM_UX_BIT] | (tiny & xr);
        next_stat[`FNM_XX_BIT] = next_stat[`FNM_XX_BIT] | xr;
        next_stat[`FNM_FR_BIT] = inc | ovf;
        next_stat[`FNM_FI_BIT] = xr;
      end else begin
        next_stat[`FNM_FR_BIT] = 1'b0;
        next_stat[`FNM_FI_BIT] = 1'b0;
      end
      if (wr_ok) next_stat[`FNM_CLS_LSB +: 5] = cls;
      if (|(next_stat[28:19] & ~stat[28:19]))
        next_stat[`FNM_FX_BIT] = 1'b1;
    end
    next_stat[`FNM_VX_BIT] = |(next_stat & `FNM_VXANY_MSK);
    next_stat[`FNM_FEX_BIT] =
      (next_stat[`FNM_VX_BIT] & next_stat[`FNM_VE_BIT]) |
      (next_stat[`FNM_OX_BIT] & next_stat[`FNM_OE_BIT]) |
      (next_stat[`FNM_UX_BIT] & next_stat[`FNM_UE_BIT]) |
      (next_stat[`FNM_ZX_BIT] & next_stat[`FNM_ZE_BIT]) |
      (next_stat[`FNM_XX_BIT] & next_stat[`FNM_XE_BIT]);
  end
  // ==========================================================
  // Status register, untouched by the sign operations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) stat <= `FNM_STAT_RST;
    else stat <= next_stat;
  end
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl <= `FNM_CTRL_RST;
    else if (apb_wr && paddr == `FNM_CTRL_OFS)
      ctrl <= strb_merge(ctrl, pwdata, pstrb) & 32'h0000_0001;
  end
  // ==========================================================
  // Result port toward the register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid  <= 1'b0;
      res_we     <= 1'b0;
      res_target <= 5'h0;
      res_data   <= 64'h0;
    end else begin
      res_valid  <= inst_valid & (op != FNM_OP_NONE);
      res_we     <= inst_valid & (op != FNM_OP_NONE) & wr_ok;
      res_target <= inst_word[25:21];
      res_data   <= fin;
    end
  end
  // Condition field copy on record form
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_we   <= 1'b0;
      cond_data <= `FNM_COND_RST;
    end else begin
      cond_we <= inst_valid & (op != FNM_OP_NONE) & inst_word[0];
      if (inst_valid && op != FNM_OP_NONE && inst_word[0])
        cond_data <= next_stat[31:28];
    end
  end
  // ==========================================================
  // APB slave, one wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready &
                 !(paddr inside {`FNM_CTRL_OFS, `FNM_STAT_OFS,
                                 `FNM_COND_OFS});
      case (paddr)
        `FNM_CTRL_OFS: prdata <= ctrl;
        `FNM_STAT_OFS: prdata <= stat;
        `FNM_COND_OFS: prdata <= {28'h0, cond_data};
        default:       prdata <= 32'h0;
      endcase
    end
  end
endmodule

// File: bench/fnm_unit_props.sv
// Checker for the negate and negative multiply-add slice
`timescale 1ns/1ps
`include "fnm_regs.svh"
module fnm_unit_props
  import fnm_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        inst_valid,
  input wire logic [31:0] inst_word,
  input wire logic [63:0] opnd_a,
  input wire logic [63:0] opnd_b,
  input wire logic [63:0] opnd_c,
  input wire logic        res_valid,
  input wire logic        res_we,
  input wire logic [4:0]  res_target,
  input wire logic [63:0] res_data,
  input wire logic        cond_we,
  input wire logic [3:0]  cond_data
);
  // ==========
  // Decode of the presented instruction
  logic dbl, nabs, neg, nma, nms, nmas, known, qa, sa, imz;
  assign dbl   = inst_valid && inst_word[31:26] == `FNM_PRIM_DBL;
  assign nabs  = dbl && inst_word[10:1] == `FNM_XO_NABS;
  assign neg   = dbl && inst_word[10:1] == `FNM_XO_NEG;
  assign nma   = dbl && inst_word[5:1] == `FNM_XO_NMADD;
  assign nms   = dbl && inst_word[5:1] == `FNM_XO_NMSUB;
  assign nmas  = inst_valid && inst_word[31:26] == `FNM_PRIM_SGL
                 && inst_word[5:1] == `FNM_XO_NMADD;
  assign known = nabs || neg || nma || nms || nmas;
  assign qa    = opnd_a[62:51] == 12'hFFF;
  assign sa    = opnd_a[62:51] == 12'hFFE && |opnd_a[50:0];
  assign imz   = opnd_a[62:0] == 63'h7FF0_0000_0000_0000
                 && opnd_c[62:0] == 63'h0 && opnd_b[62:52] != 11'h7FF;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Properties
  a_answer_next: assert property (known |=> res_valid
    && res_target == $past(inst_word[25:21])) else $error("no answer");
  a_unknown_idle: assert property (inst_valid && !known |=>
    !res_valid) else $error("answer to unknown opcode");
  a_nabs_sign: assert property (nabs |=>
    res_data == {1'b1, $past(opnd_b[62:0])}) else $error("nabs");
  a_neg_sign: assert property (neg |=> res_data ==
    {~$past(opnd_b[63]), $past(opnd_b[62:0])}) else $error("neg");
  a_sign_ops_we: assert property (nabs || neg |=> res_we)
    else $error("sign op not written");
  a_record_cond: assert property (known |=>
    cond_we == $past(inst_word[0])) else $error("record bit");
  a_qnan_keep: assert property (nma && qa |=>
    res_data == $past(opnd_a)) else $error("qnan sign");
  a_snan_quiet: assert property (nma && sa |=> !res_we ||
    res_data == ($past(opnd_a) | `FNM_QUIET_MSK)) else $error("snan");
  a_invalid_dflt: assert property (nma && imz |=> !res_we ||
    res_data == `FNM_DFLT_QNAN) else $error("default qnan");
endmodule
bind fnm_unit fnm_unit_props u_fnm_unit_props (.pclk(pclk),
  .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .inst_valid(inst_valid),
  .inst_word(inst_word), .opnd_a(opnd_a), .opnd_b(opnd_b),
  .opnd_c(opnd_c), .res_valid(res_valid), .res_we(res_we),
  .res_target(res_target), .res_data(res_data), .cond_we(cond_we),
  .cond_data(cond_data));

// File: bench/fnm_dispatch_model.sv
// Dispatch and register file model feeding the slice
`timescale 1ns/1ps
module fnm_dispatch_model (
  input  wire logic        pclk,
  output logic             inst_valid,
  output logic      [31:0] inst_word,
  output logic      [63:0] opnd_a,
  output logic      [63:0] opnd_b,
  output logic      [63:0] opnd_c
);
  initial inst_valid = 1'b0;
  initial inst_word = 32'h0000_0000;
  initial {opnd_a, opnd_b, opnd_c} = '0;
  // One instruction for one cycle; idle lines then show inverted values
  task automatic issue(input logic [31:0] w, input logic [63:0] a,
                       input logic [63:0] b, input logic [63:0] c);
    @(posedge pclk);
    inst_valid <= 1'b1;
    {inst_word, opnd_a, opnd_b, opnd_c} <= {w, a, b, c};
    @(posedge pclk);
    inst_valid <= 1'b0;
    {inst_word, opnd_a, opnd_b, opnd_c} <= ~{w, a, b, c};
  endtask
endmodule

// File: bench/fnm_unit_tb.sv
// Self-checking bench for the negate and negative multiply-add slice
`timescale 1ns/1ps
module fnm_unit_tb;
  typedef struct packed {
    logic [31:0] w; logic [63:0] a, b, c, r;
  } fnm_row_s;
  localparam logic [31:0] NAB = 32'hFC00_0110, NEG = 32'hFC00_0050;
  localparam logic [31:0] NMA = 32'hFC00_003E, NMS = 32'hFC00_003C;
  localparam logic [31:0] NMF = 32'hEC00_003E;
  localparam logic [63:0] Z = 64'h0, ONE = 64'h3FF0_0000_0000_0000;
  localparam logic [63:0] TWO = 64'h4000_0000_0000_0000;
  localparam logic [63:0] M3 = 64'hC008_0000_0000_0000;
  localparam logic [63:0] INF = 64'h7FF0_0000_0000_0000;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000, prdata, s0, s1;
  logic        pready, pslverr, res_valid, res_we, cond_we, er;
  logic        inst_valid;
  logic [31:0] inst_word;
  logic [63:0] opnd_a, opnd_b, opnd_c, res_data;
  logic [4:0]  res_target;
  logic [3:0]  cond_data;
  int          miscompares = 0, n_checks = 0;
  fnm_row_s    rows [11];
  always #2.5 pclk = ~pclk;
  fnm_dispatch_model u_fnm_dispatch_model (.pclk(pclk),
    .inst_valid(inst_valid), .inst_word(inst_word), .opnd_a(opnd_a),
    .opnd_b(opnd_b), .opnd_c(opnd_c));
  fnm_unit u_fnm_unit (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .inst_valid(inst_valid), .inst_word(inst_word), .opnd_a(opnd_a),
    .opnd_b(opnd_b), .opnd_c(opnd_c), .res_valid(res_valid),
    .res_we(res_we), .res_target(res_target), .res_data(res_data),
    .cond_we(cond_we), .cond_data(cond_data));
  // ==========
  // Helpers
  function automatic logic [31:0] enc(logic [31:0] b, logic [4:0] d,
                                      logic rc);
    return b | {6'h00, d, 21'h00_0000} | {31'h0000_0000, rc};
  endfunction
  task automatic chk64(string nm, logic [63:0] e, logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    chk64(nm, {32'h0000_0000, e}, {32'h0000_0000, g});
  endtask
  // APB transfer: setup, access, wait for pready
  task automatic apb(logic w, logic [11:0] ad, logic [31:0] wd);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n == 20) miscompares++;
    s1 = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic run(logic [31:0] w, logic [63:0] a, logic [63:0] b,
                     logic [63:0] c);
    u_fnm_dispatch_model.issue(w, a, b, c);
    #1;
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    miscompares++;
    give_verdict();
  end
  // ==========
  // Main sequence
  initial begin
    rows = '{'{NAB, Z, ONE, Z, 64'hBFF0_0000_0000_0000},
      '{NAB, Z, 64'hC000_0000_0000_0000, Z, 64'hC000_0000_0000_0000},
      '{NEG, Z, 64'h7FF8_0000_0000_0000, Z, 64'hFFF8_0000_0000_0000},
      '{NEG, Z, 64'h8000_0000_0000_0000, Z, Z},
      '{NMA, ONE, ONE, TWO, M3}, '{NMS, TWO, ONE, TWO, M3},
      '{NMA, ONE, 64'hBFE8_0000_0000_0000, ONE,
        64'hBFD0_0000_0000_0000},
      '{NMF, ONE, ONE, TWO, M3},
      '{NMA, 64'h7FF8_0000_0000_0001, ONE, ONE,
        64'h7FF8_0000_0000_0001},
      '{NMA, 64'hFFF0_0000_0000_0001, ONE, ONE,
        64'hFFF8_0000_0000_0001},
      '{NMA, INF, ONE, Z, 64'h7FF8_0000_0000_0000}};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk32("status reset", 32'h0000_0000, s1);
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk32("ctrl reset", 32'h0000_0000, s1);
    run(enc(NAB, 5'd3, 1'b1), Z, ONE, Z);
    chk32("clean cond", 32'h0000_0010,
          {27'h0, cond_we, cond_data});
    for (int i = 0; i < 11; i++) begin
      run(enc(rows[i].w, 5'(i + 1), i[0]), rows[i].a, rows[i].b, rows[i].c);
      chk64("result", rows[i].r, res_data);
      chk32("flags", {24'h0, 1'b1, 1'b1, i[0], 5'(i + 1)},
            {24'h0, res_valid, res_we, cond_we, res_target});
    end
    run(enc(NMA, 5'd7, 1'b1), INF, ONE, Z);
    chk32("invalid cond", 32'h0000_001A,
          {27'h0, cond_we, cond_data});
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk32("cond reg", 32'h0000_000A, s1);
    apb(1'b0, 12'h004, 32'h0000_0000);
    s0 = s1;
    chk32("sticky", 32'hF,
          {28'h0, s1[31], s1[29], s1[24], s1[20]});
    run(enc(NAB, 5'd2, 1'b0), Z, 64'h7FF8_0000_0000_0000, Z);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk32("status kept", s0, s1);
    apb(1'b1, 12'h004, 32'h0000_0002);
    run(enc(NMA, 5'd4, 1'b0), ONE, 64'h3C30_0000_0000_0000, ONE);
    chk64("round up", 64'hBFF0_0000_0000_0001, res_data);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk32("class", 32'h0000_0028, {26'h0, s1[17], s1[16:12]});
    apb(1'b1, 12'h000, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_0000);
    run(enc(NMF, 5'd5, 1'b0), 64'h1234_5678_3F80_0000,
        64'h1234_5678_3F80_0000, 64'h9ABC_0000_4000_0000);
    chk64("paired", 64'hC040_0000_C040_0000, res_data);
    apb(1'b1, 12'h000, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0080);
    run(enc(NMA, 5'd6, 1'b0), INF, ONE, Z);
    chk32("trap we", 32'h2, {30'h0, res_valid, res_we});
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk32("class kept", 32'h0, {27'h0, s1[16:12]});
    run(32'h0000_0000, ONE, ONE, ONE);
    chk32("unknown", 32'h0, {31'h0, res_valid});
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk32("unmapped", 32'h1, {31'h0, er});
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk32("status rereset", 32'h0000_0000, s1);
    give_verdict();
  end
endmodule
